// ### brfs_defs.vh
`ifndef BRFS_DEFS_VH
`define BRFS_DEFS_VH

// read select codes, taken from the address field of a read frame
`define BRFS_SEL_W             5
`define BRFS_SEL_OC_UPPER      5'h1E
`define BRFS_SEL_OL_LOWER      5'h01

// register width and reset values
`define BRFS_REG_W             8
`define BRFS_OC_UPPER_RST      8'h00
`define BRFS_OL_LOWER_RST      8'h00
`define BRFS_UNMAPPED_DATA     8'h00

// field positions, same layout in both registers
`define BRFS_SLOT3_HIGH        7
`define BRFS_SLOT3_LOW         6
`define BRFS_SLOT2_HIGH        5
`define BRFS_SLOT2_LOW         4
`define BRFS_SLOT1_HIGH        3
`define BRFS_SLOT1_LOW         2
`define BRFS_SLOT0_HIGH        1
`define BRFS_SLOT0_LOW         0

// timing: detector levels pass two flip-flops, read answer after one edge
`define BRFS_SYNC_STAGES       2
`define BRFS_RD_LATENCY        1

`endif

// ### brfs_sync.v
`timescale 1ns/1ps
`include "brfs_defs.vh"

module brfs_sync #(
  parameter WIDTH = 16
) (
  input  wire             clk_sys,
  input  wire             srst,
  input  wire             ce,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  // first stage is read by the second stage only
  reg [WIDTH-1:0] meta;

  always @(posedge clk_sys) begin
    if (srst) begin
      meta     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else if (ce) begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// ### brfs_regs.v
`timescale 1ns/1ps
`include "brfs_defs.vh"

module brfs_regs (
  input  wire                     clk_sys,
  input  wire                     srst,
  input  wire                     ce,
  // raw overcurrent detector levels, bridges 9 to 12
  input  wire                     bridge12_high_overcurrent,
  input  wire                     bridge12_low_overcurrent,
  input  wire                     bridge11_high_overcurrent,
  input  wire                     bridge11_low_overcurrent,
  input  wire                     bridge10_high_overcurrent,
  input  wire                     bridge10_low_overcurrent,
  input  wire                     bridge9_high_overcurrent,
  input  wire                     bridge9_low_overcurrent,
  // raw open-load detector levels, bridges 1 to 4
  input  wire                     bridge4_high_openload,
  input  wire                     bridge4_low_openload,
  input  wire                     bridge3_high_openload,
  input  wire                     bridge3_low_openload,
  input  wire                     bridge2_high_openload,
  input  wire                     bridge2_low_openload,
  input  wire                     bridge1_high_openload,
  input  wire                     bridge1_low_openload,
  // switch-on requests from the bridge control logic, status bit order
  input  wire [`BRFS_REG_W-1:0]   upper_switch_req,
  input  wire [`BRFS_REG_W-1:0]   lower_switch_req,
  // register read port from the serial frame decoder
  input  wire                     rd_req,
  input  wire [`BRFS_SEL_W-1:0]   rd_sel,
  output reg  [`BRFS_REG_W-1:0]   rd_data,
  output reg                      rd_valid,
  // live register contents
  output reg  [`BRFS_REG_W-1:0]   overcurrent_status_upper,
  output reg  [`BRFS_REG_W-1:0]   open_load_status_lower,
  // gate drive enables, upper after overcurrent protection, lower passed through unprotected
  output reg  [`BRFS_REG_W-1:0]   upper_switch_drive,
  output reg  [`BRFS_REG_W-1:0]   lower_switch_drive
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // sticky update: a fault seen in the clearing cycle survives the clear
  function [`BRFS_REG_W-1:0] sticky_next;
    input [`BRFS_REG_W-1:0] cur;
    input [`BRFS_REG_W-1:0] evt;
    input                   clr;
    begin
      if (clr) begin
        sticky_next = evt;
      end else begin
        sticky_next = cur | evt;
      end
    end
  endfunction

  // place four bridges, high side above low side, highest bridge on top
  function [`BRFS_REG_W-1:0] pack_slots;
    input s3_high;
    input s3_low;
    input s2_high;
    input s2_low;
    input s1_high;
    input s1_low;
    input s0_high;
    input s0_low;
    begin
      pack_slots                   = `BRFS_OC_UPPER_RST;
      pack_slots[`BRFS_SLOT3_HIGH] = s3_high;
      pack_slots[`BRFS_SLOT3_LOW]  = s3_low;
      pack_slots[`BRFS_SLOT2_HIGH] = s2_high;
      pack_slots[`BRFS_SLOT2_LOW]  = s2_low;
      pack_slots[`BRFS_SLOT1_HIGH] = s1_high;
      pack_slots[`BRFS_SLOT1_LOW]  = s1_low;
      pack_slots[`BRFS_SLOT0_HIGH] = s0_high;
      pack_slots[`BRFS_SLOT0_LOW]  = s0_low;
    end
  endfunction

  // one compare per select code, shared by the data mux and the clears
  function sel_hit;
    input                   req;
    input [`BRFS_SEL_W-1:0] sel;
    input [`BRFS_SEL_W-1:0] code;
    begin
      sel_hit = req && (sel == code);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // detector synchronisation

  wire [2*`BRFS_REG_W-1:0] raw_faults;
  wire [2*`BRFS_REG_W-1:0] sync_faults;

  assign raw_faults = {
    pack_slots(bridge12_high_overcurrent, bridge12_low_overcurrent,
               bridge11_high_overcurrent, bridge11_low_overcurrent,
               bridge10_high_overcurrent, bridge10_low_overcurrent,
               bridge9_high_overcurrent,  bridge9_low_overcurrent),
    pack_slots(bridge4_high_openload, bridge4_low_openload,
               bridge3_high_openload, bridge3_low_openload,
               bridge2_high_openload, bridge2_low_openload,
               bridge1_high_openload, bridge1_low_openload)
  };

  // detectors are analog comparators, asynchronous to clk_sys
  brfs_sync #(
    .WIDTH    (2*`BRFS_REG_W)
  ) u_sync (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .ce       (ce),
    .async_in (raw_faults),
    .sync_out (sync_faults)
  );

  wire [`BRFS_REG_W-1:0] oc_event;
  wire [`BRFS_REG_W-1:0] ol_event;

  assign oc_event = sync_faults[2*`BRFS_REG_W-1:`BRFS_REG_W];
  assign ol_event = sync_faults[`BRFS_REG_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // read decode

  wire rd_hit_oc;
  wire rd_hit_ol;

  assign rd_hit_oc = sel_hit(rd_req, rd_sel, `BRFS_SEL_OC_UPPER);
  assign rd_hit_ol = sel_hit(rd_req, rd_sel, `BRFS_SEL_OL_LOWER);

  reg [`BRFS_REG_W-1:0] next_rd_data;

  always @* begin
    if (rd_hit_oc) begin
      next_rd_data = overcurrent_status_upper;
    end else if (rd_hit_ol) begin
      next_rd_data = open_load_status_lower;
    end else begin
      // unmapped select answers with zero and clears nothing
      next_rd_data = `BRFS_UNMAPPED_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status latches

  wire [`BRFS_REG_W-1:0] next_oc_status;
  wire [`BRFS_REG_W-1:0] next_ol_status;

  // a level still present re-sets its bit in the same edge as the clear
  assign next_oc_status = sticky_next(overcurrent_status_upper, oc_event, rd_hit_oc);
  assign next_ol_status = sticky_next(open_load_status_lower, ol_event, rd_hit_ol);

  // overcurrent bits, bridges 9 to 12
  always @(posedge clk_sys) begin
    if (srst) begin
      overcurrent_status_upper <= `BRFS_OC_UPPER_RST;
    end else if (ce) begin
      overcurrent_status_upper <= next_oc_status;
    end
  end

  // open-load bits, bridges 1 to 4
  always @(posedge clk_sys) begin
    if (srst) begin
      open_load_status_lower <= `BRFS_OL_LOWER_RST;
    end else if (ce) begin
      open_load_status_lower <= next_ol_status;
    end
  end

  // read answer, one edge after the strobe
  // rd_valid pulses once for every cycle the strobe is high while ce is set
  always @(posedge clk_sys) begin
    if (srst) begin
      rd_data  <= `BRFS_UNMAPPED_DATA;
      rd_valid <= 1'b0;
    end else if (ce) begin
      // returned value is the one before this read's clear
      rd_data  <= next_rd_data;
      rd_valid <= rd_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // switch protection

  wire [`BRFS_REG_W-1:0] next_upper_drive;

  // drive follows the updated status, so the cut lands with the set
  assign next_upper_drive = upper_switch_req & ~next_oc_status;

  // a faulted switch stays off while its bit is latched, so the host has
  // to read the fault before the switch can come back
  always @(posedge clk_sys) begin
    if (srst) begin
      upper_switch_drive <= {`BRFS_REG_W{1'b0}};
    end else if (ce) begin
      upper_switch_drive <= next_upper_drive;
    end
  end

  // open load is reported only, the switch keeps running
  always @(posedge clk_sys) begin
    if (srst) begin
      lower_switch_drive <= {`BRFS_REG_W{1'b0}};
    end else if (ce) begin
      lower_switch_drive <= lower_switch_req;
    end
  end

endmodule

// ### brfs_regs_assertions.sv
`timescale 1ns/1ps
`include "brfs_defs.vh"
module brfs_chk (
  input logic       clk_sys,
  input logic       srst,
  input logic       ce,
  input logic       rd_req,
  input logic [4:0] rd_sel,
  input logic [7:0] rd_data,
  input logic       rd_valid,
  input logic [7:0] overcurrent_status_upper,
  input logic [7:0] open_load_status_lower,
  input logic [7:0] upper_switch_req,
  input logic [7:0] lower_switch_req,
  input logic [7:0] upper_switch_drive,
  input logic [7:0] lower_switch_drive
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_rd; ce && rd_req; endsequence
  sequence s_oc; ce && rd_req && rd_sel == `BRFS_SEL_OC_UPPER; endsequence
  sequence s_ol; ce && rd_req && rd_sel == `BRFS_SEL_OL_LOWER; endsequence
  AST_RD_ANSWER: assert property (s_rd |=> rd_valid) else $error("read not answered");
  AST_RD_QUIET: assert property (ce && !rd_req |=> !rd_valid) else $error("stray read answer");
  AST_OC_DATA: assert property (s_oc |=> rd_data == $past(overcurrent_status_upper))
    else $error("overcurrent read data wrong");
  AST_OL_DATA: assert property (s_ol |=> rd_data == $past(open_load_status_lower))
    else $error("open-load read data wrong");
  AST_OC_HOLD: assert property (ce && !rd_req |=>
    (overcurrent_status_upper & $past(overcurrent_status_upper)) == $past(overcurrent_status_upper))
    else $error("overcurrent bit lost without read");
  AST_OC_CUT: assert property (ce |=>
    upper_switch_drive == ($past(upper_switch_req) & ~overcurrent_status_upper))
    else $error("faulted switch still driven");
  AST_OL_RUN: assert property (ce |=> lower_switch_drive == $past(lower_switch_req))
    else $error("open load altered drive");
  AST_RST_CLEAR: assert property ($fell(srst) |->
    overcurrent_status_upper == 8'h00 && open_load_status_lower == 8'h00)
    else $error("status not clear after reset");
endmodule
bind brfs_regs brfs_chk u_chk (.clk_sys, .srst, .ce, .rd_req, .rd_sel, .rd_data, .rd_valid, .overcurrent_status_upper,
  .open_load_status_lower, .upper_switch_req, .lower_switch_req, .upper_switch_drive, .lower_switch_drive);

// ### brfs_host.sv
`timescale 1ns/1ps
module brfs_host (
  input  logic       clk_sys,
  input  logic [7:0] rd_data,
  input  logic       rd_valid,
  output logic       rd_req,
  output logic [4:0] rd_sel
);
  initial begin
    rd_req = 1'b0;
    rd_sel = 5'h00;
  end
  // idle select shows the inverse, so a stale select is never mistaken for a live one
  task automatic rd(input logic [4:0] s, output logic [7:0] d, input int gap);
    int k;
    repeat (gap) @(posedge clk_sys);
    rd_req <= 1'b1;
    rd_sel <= s;
    @(posedge clk_sys);
    rd_req <= 1'b0;
    rd_sel <= ~s;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (rd_valid !== 1'b1 && k < 4);
    d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
  endtask
endmodule

// ### test_bridge_fault_status_regs.sv
`timescale 1ns/1ps
`include "brfs_defs.vh"
module test_bridge_fault_status_regs;
  logic       clk_sys, srst, ce, rd_req, rd_valid;
  logic [4:0] rd_sel;
  logic [7:0] oc, ol, ureq, lreq, rd_data, ocs, ols, udrv, ldrv, a, b, r, d;
  int         seed = 66665, n_fail = 0, tests_run = 0, i;
  brfs_regs DUT (.clk_sys, .srst, .ce, .rd_req, .rd_sel, .rd_data, .rd_valid,
    .bridge12_high_overcurrent(oc[7]), .bridge12_low_overcurrent(oc[6]), .bridge11_high_overcurrent(oc[5]),
    .bridge11_low_overcurrent(oc[4]), .bridge10_high_overcurrent(oc[3]), .bridge10_low_overcurrent(oc[2]),
    .bridge9_high_overcurrent(oc[1]), .bridge9_low_overcurrent(oc[0]), .bridge4_high_openload(ol[7]),
    .bridge4_low_openload(ol[6]), .bridge3_high_openload(ol[5]), .bridge3_low_openload(ol[4]),
    .bridge2_high_openload(ol[3]), .bridge2_low_openload(ol[2]), .bridge1_high_openload(ol[1]),
    .bridge1_low_openload(ol[0]), .upper_switch_req(ureq), .lower_switch_req(lreq), .overcurrent_status_upper(ocs),
    .open_load_status_lower(ols), .upper_switch_drive(udrv), .lower_switch_drive(ldrv));
  brfs_host host (.clk_sys, .rd_data, .rd_valid, .rd_req, .rd_sel);
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [7:0] cut(input logic [7:0] q, input logic [7:0] f);
    return q & ~f;
  endfunction
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    finish_test();
  end
  initial begin
    {srst, ce, oc, ol, ureq, lreq} = {1'b1, 1'b1, 32'h0};
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    host.rd(`BRFS_SEL_OC_UPPER, d, 0);
    chk("oc reset", 8'h00, d);
    host.rd(`BRFS_SEL_OL_LOWER, d, 0);
    chk("ol reset", 8'h00, d);
    // enable low: faults and requests must reach no state at all
    ce <= 1'b0;
    oc <= 8'hFF;
    ol <= 8'hFF;
    ureq <= 8'hFF;
    lreq <= 8'hFF;
    repeat (6) @(posedge clk_sys);
    chk("ce oc frozen", 8'h00, ocs);
    chk("ce ol frozen", 8'h00, ols);
    chk("ce upper frozen", 8'h00, udrv);
    chk("ce lower frozen", 8'h00, ldrv);
    oc <= 8'h00;
    ol <= 8'h00;
    ce <= 1'b1;
    for (i = 0; i < 16; i++) begin
      a = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : 8'($random(seed));
      b = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : 8'($random(seed));
      r = 8'($random(seed));
      oc <= a;
      ol <= b;
      ureq <= r;
      lreq <= ~r;
      repeat (5) @(posedge clk_sys);
      chk("oc drive", cut(r, a), udrv);
      chk("ol drive", ~r, ldrv);
      chk("oc live", a, ocs);
      chk("ol live", b, ols);
      // fault still present during this read, so the set must win over the clear
      host.rd(`BRFS_SEL_OC_UPPER, d, 0);
      chk("oc held", a, d);
      chk("oc set wins", a, ocs);
      oc <= 8'h00;
      ol <= 8'h00;
      repeat (3) @(posedge clk_sys);
      host.rd(5'h0A, d, {$random(seed)} % 3);
      chk("unmapped", `BRFS_UNMAPPED_DATA, d);
      host.rd(`BRFS_SEL_OC_UPPER, d, {$random(seed)} % 3);
      chk("oc status", a, d);
      host.rd(`BRFS_SEL_OL_LOWER, d, 0);
      chk("ol status", b, d);
      host.rd(`BRFS_SEL_OC_UPPER, d, 0);
      chk("oc cleared", 8'h00, d);
      host.rd(`BRFS_SEL_OL_LOWER, d, 0);
      chk("ol cleared", 8'h00, d);
      chk("oc live cleared", 8'h00, ocs);
      chk("ol live cleared", 8'h00, ols);
      chk("oc drive back", r, udrv);
    end
    // mid-run reset with faults latched brings every bit back to zero
    oc <= 8'h5A;
    ol <= 8'hA5;
    repeat (5) @(posedge clk_sys);
    chk("oc before reset", 8'h5A, ocs);
    chk("ol before reset", 8'hA5, ols);
    srst <= 1'b1;
    oc <= 8'h00;
    ol <= 8'h00;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    chk("oc after reset", 8'h00, ocs);
    chk("ol after reset", 8'h00, ols);
    chk("drive after reset", 8'h00, udrv);
    host.rd(`BRFS_SEL_OC_UPPER, d, 0);
    chk("oc read after reset", 8'h00, d);
    host.rd(`BRFS_SEL_OL_LOWER, d, 0);
    chk("ol read after reset", 8'h00, d);
    finish_test();
  end
endmodule
